// ### hdl/usr_pkg.sv
// shared constants and carrier types for the serial receiver with spi framing
package usr_pkg;
    // operating mode field encodings
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_SPI = 2'h3;
    // character size code selecting nine data bits
    localparam logic [2:0] CS_NINE = 3'h7;
    localparam logic [3:0] CS_BASE_BITS = 4'h5;
    localparam logic [3:0] NINE_BITS = 4'h9;
    // oversampling: samples per bit and centre sample index
    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;
    localparam logic [4:0] MID_NORMAL = 5'h09;
    localparam logic [4:0] MID_DOUBLE = 5'h05;
    // spi: clock edges per byte, fill shifted out when nothing was written
    localparam logic [4:0] SPI_EDGES = 5'h10;
    localparam logic [7:0] TX_IDLE_FILL = 8'hFF;
    // receive buffer depth
    localparam int RX_DEPTH_DEF = 2;

    typedef struct packed {
        logic dor;
        logic fe;
        logic pe;
        logic bit8;
        logic [7:0] data;
    } usr_entry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PAR,
        ST_STOP
    } usr_state_t;
endpackage

// ### hdl/usr_rx_top.sv
// receive path, receive buffer and spi engine of the serial unit
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - receiver runs only while enabled
// - shift bits after start until first stop
// - ninth data bit goes to ninth-bit flag
// - two-entry buffer keeps flags with data
// - complete flag high while buffer holds data
// - disable stops, flushes, clears complete flag
// - interrupt while flag, enable, global enable
// - frame error set when stop sampled low
// - full buffer: overrun, drop until read
// - parity error reads zero when parity off
// - check parity of data against parity bit
// - oversample sixteen, or eight double speed
// - start confirmed by samples eight-nine-ten majority, four-five-six at double speed
// - data bits by centre three-sample majority
// - stop needs two of three high, idle
// - spi slave select input or master output
// - cpol and cpha choose sample edges
// - cpha zero: slave drives at select fall
// - cpha one: first edge shifts, next samples
// - spi master transfer starts on data write
// - master clock runs without transmit enable
// - five to nine bits, parity, lsb first

module usr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    wire do_push = i_in_valid & o_in_ready;
    wire do_pop = o_out_valid & i_out_ready;
    wire [AW-1:0] last = AW'(DEPTH - 1);

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rptr];

    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_flush) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wptr <= (wptr == last) ? '0 : wptr + 1'b1;
            end
            if (do_pop) begin
                rptr <= (rptr == last) ? '0 : rptr + 1'b1;
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

module usr_rx_top import usr_pkg::*; #(
    parameter int RX_DEPTH = RX_DEPTH_DEF
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rx_enable_bit,
    input wire logic [1:0] i_operating_mode_field,
    input wire logic [2:0] i_char_size_field,
    input wire logic i_parity_enable_bit,
    input wire logic i_parity_odd,
    input wire logic i_double_speed_bit,
    input wire logic i_master,
    input wire logic i_clock_polarity_bit,
    input wire logic i_clock_phase_bit,
    input wire logic i_lsb_first,
    input wire logic i_slave_select_enable,
    input wire logic i_rx_complete_irq_enable,
    input wire logic i_global_irq_enable,
    input wire logic i_baud_tick,
    input wire logic i_serial_in_pin,
    input wire logic i_serial_clock_pin,
    input wire logic i_slave_select_pin,
    input wire logic i_data_write,
    input wire logic [7:0] i_write_data,
    input wire logic i_data_read,
    output logic [7:0] o_rx_data,
    output logic o_rx_ninth_bit,
    output logic o_frame_error_flag,
    output logic o_overrun_flag,
    output logic o_parity_error_flag,
    output logic o_rx_complete_flag,
    output logic o_rx_irq,
    output logic o_tx_buffer_empty_flag,
    output logic o_serial_out,
    output logic o_serial_out_oe,
    output logic o_serial_clock_out,
    output logic o_serial_clock_oe,
    output logic o_slave_select_out,
    output logic o_slave_select_oe,
    output logic o_serial_in_claimed
);
    logic rx_m, rx_s, rx_prev;
    logic sck_m, sck_s, sck_d;
    logic ss_m, ss_s, ss_d;
    usr_state_t state, next_state;
    logic [4:0] cnt;
    logic [1:0] votes;
    logic [3:0] bidx;
    logic [8:0] sh;
    logic par;
    logic spi_busy, first, sck_int, ovr_pend, ovr_mark;
    logic [4:0] ecnt;
    logic [7:0] txsh, rxsh, tx_buf;
    usr_entry_t fifo_in, head;
    logic fifo_in_ready, fifo_out_valid;

    // mode and timing decode
    wire rx_en = i_rx_enable_bit;
    wire spi = (i_operating_mode_field == MODE_SPI);
    wire sync_mode = (i_operating_mode_field == MODE_SYNC);
    wire async = (i_operating_mode_field == MODE_ASYNC);
    wire [4:0] os_len = i_double_speed_bit ? OS_DOUBLE : OS_NORMAL;
    wire [4:0] mid = i_double_speed_bit ? MID_DOUBLE : MID_NORMAL;
    wire [4:0] cur = (cnt == os_len) ? 5'h01 : cnt + 5'h01;
    wire tick = i_baud_tick;
    wire maj = (votes[0] & votes[1]) | (votes[0] & rx_s) | (votes[1] & rx_s);
    wire async_fall = async & rx_en & tick & rx_prev & ~rx_s & (state == ST_IDLE);
    wire async_evt = async & tick & (state != ST_IDLE) & (cur == mid + 5'h01);
    wire [3:0] nbits = (i_char_size_field == CS_NINE) ? NINE_BITS
                                                      : CS_BASE_BITS + {2'h0, i_char_size_field[1:0]};
    // clock edge selection, shared by sync uart and spi
    wire pin_rise = sck_s & ~sck_d;
    wire pin_fall = ~sck_s & sck_d;
    wire sck_act = i_clock_polarity_bit ^ sck_int;
    wire mtog = spi_busy & i_master & tick & (ecnt != SPI_EDGES);
    wire own_clk = spi & i_master;
    wire edge_rise = own_clk ? (mtog & ~sck_act) : pin_rise;
    wire edge_fall = own_clk ? (mtog & sck_act) : pin_fall;
    wire samp_rise = spi ? ~(i_clock_polarity_bit ^ i_clock_phase_bit) : i_clock_polarity_bit;
    wire sample_edge = samp_rise ? edge_rise : edge_fall;
    wire shift_edge = samp_rise ? edge_fall : edge_rise;
    wire bit_evt = async ? async_evt : (sync_mode & sample_edge);
    wire bit_val = async ? maj : rx_s;
    wire frame_done = rx_en & (state == ST_STOP) & bit_evt;
    // spi control
    wire spi_start_m = spi & i_master & ~spi_busy & ~o_tx_buffer_empty_flag;
    wire spi_start_s = spi & ~i_master & ~spi_busy & ss_d & ~ss_s;
    wire spi_abort = spi_busy & (~spi | (~i_master & ss_s));
    wire spi_step = spi_busy & (sample_edge | shift_edge);
    wire spi_end = spi_step & (ecnt == SPI_EDGES - 5'h01);
    wire spi_keep = spi_end & ~i_master & i_clock_phase_bit & ~ss_s;
    wire [7:0] next_rxsh = i_lsb_first ? {rx_s, rxsh[7:1]} : {rxsh[6:0], rx_s};
    wire [7:0] spi_word = sample_edge ? next_rxsh : rxsh;
    wire [7:0] tx_load = o_tx_buffer_empty_flag ? TX_IDLE_FILL : tx_buf;
    wire tx_take = spi_start_m | spi_start_s | spi_keep;
    wire out_bit = i_lsb_first ? txsh[0] : txsh[7];
    // buffer hand-off
    wire push_req = frame_done | (rx_en & spi_end);
    wire pop = i_data_read & fifo_out_valid;
    wire par_err = i_parity_enable_bit & par;

    always_comb begin
        fifo_in.data = spi ? spi_word : sh[7:0];
        fifo_in.bit8 = ~spi & (nbits == NINE_BITS) & sh[8];
        fifo_in.pe = ~spi & par_err;
        fifo_in.fe = ~spi & ~bit_val;
        fifo_in.dor = ovr_mark;
    end

    usr_fifo #(
        .WIDTH($bits(usr_entry_t)),
        .DEPTH(RX_DEPTH)
    ) usr_fifo_inst (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_flush(~rx_en),
        .i_in_valid(push_req & ~ovr_pend),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(i_data_read),
        .o_out_data(head)
    );

    // pin synchronisers
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            {rx_m, rx_s, ss_m, ss_s, ss_d} <= 5'h1F;
            {sck_m, sck_s, sck_d} <= 3'h0;
        end else begin
            {rx_m, rx_s} <= {i_serial_in_pin, rx_m};
            {ss_m, ss_s, ss_d} <= {i_slave_select_pin, ss_m, ss_s};
            {sck_m, sck_s, sck_d} <= {i_serial_clock_pin, sck_m, sck_s};
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (async_fall || (sync_mode && sample_edge && !rx_s)) begin
                    next_state = async ? ST_START : ST_DATA;
                end
            end
            ST_START: begin
                if (async_evt) begin
                    next_state = maj ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (bit_evt && bidx == nbits - 4'h1) begin
                    next_state = i_parity_enable_bit ? ST_PAR : ST_STOP;
                end
            end
            ST_PAR: begin
                if (bit_evt) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (bit_evt) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (!rx_en || spi) begin
            next_state = ST_IDLE;
        end
    end

    // async sample counter, resynchronised on every start edge
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            cnt <= 5'h00;
            votes <= 2'h3;
            rx_prev <= 1'b1;
        end else begin
            state <= next_state;
            if (tick) begin
                rx_prev <= rx_s;
            end
            if (async_fall) begin
                cnt <= 5'h01;
            end else if (tick && state != ST_IDLE) begin
                cnt <= cur;
                if (cur == mid - 5'h01) begin
                    votes[0] <= rx_s;
                end
                if (cur == mid) begin
                    votes[1] <= rx_s;
                end
            end
        end
    end

    // frame assembly, lsb first
    always_ff @(posedge i_clk) begin
        if (!i_resetn || state == ST_IDLE) begin
            bidx <= 4'h0;
            sh <= 9'h000;
            par <= 1'b0;
        end else if (bit_evt && state == ST_DATA) begin
            sh[bidx] <= bit_val;
            bidx <= bidx + 4'h1;
            par <= par ^ bit_val;
        end else if (bit_evt && state == ST_PAR) begin
            par <= par ^ bit_val ^ i_parity_odd;
        end
    end

    // overrun: hold off pushes until a read frees space, flag the next entry
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !rx_en) begin
            ovr_pend <= 1'b0;
            ovr_mark <= 1'b0;
        end else begin
            if (push_req && (!fifo_in_ready || ovr_pend)) begin
                ovr_pend <= 1'b1;
            end else if (pop) begin
                ovr_pend <= 1'b0;
            end
            if (push_req && (!fifo_in_ready || ovr_pend)) begin
                ovr_mark <= 1'b1;
            end else if (push_req) begin
                ovr_mark <= 1'b0;
            end
        end
    end

    // spi engine: 16 clock edges per byte
    always_ff @(posedge i_clk) begin
        if (!i_resetn || spi_abort) begin
            spi_busy <= 1'b0;
            ecnt <= 5'h00;
            first <= 1'b1;
            sck_int <= 1'b0;
            txsh <= TX_IDLE_FILL;
            rxsh <= 8'h00;
        end else begin
            if (tx_take) begin
                spi_busy <= 1'b1;
                ecnt <= 5'h00;
                first <= 1'b1;
                txsh <= tx_load;
            end else if (spi_end) begin
                spi_busy <= 1'b0;
                sck_int <= 1'b0;
            end else if (spi_step) begin
                ecnt <= ecnt + 5'h01;
            end
            if (mtog && !spi_end) begin
                sck_int <= ~sck_int;
            end
            if (spi_busy && sample_edge) begin
                rxsh <= next_rxsh;
            end
            if (spi_busy && shift_edge && !tx_take) begin
                first <= 1'b0;
                if (!(i_clock_phase_bit && first)) begin
                    txsh <= i_lsb_first ? {1'b1, txsh[7:1]} : {txsh[6:0], 1'b1};
                end
            end
        end
    end

    // transmit holding buffer; a write in the load cycle wins
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tx_buf <= 8'h00;
            o_tx_buffer_empty_flag <= 1'b1;
        end else if (i_data_write) begin
            tx_buf <= i_write_data;
            o_tx_buffer_empty_flag <= 1'b0;
        end else if (tx_take) begin
            o_tx_buffer_empty_flag <= 1'b1;
        end
    end

    // registered outputs
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rx_data <= 8'h00;
            {o_rx_ninth_bit, o_frame_error_flag, o_overrun_flag, o_parity_error_flag} <= 4'h0;
            {o_rx_complete_flag, o_rx_irq, o_serial_in_claimed} <= 3'h0;
            {o_serial_out, o_serial_clock_out, o_slave_select_out} <= 3'h7;
            {o_serial_out_oe, o_serial_clock_oe, o_slave_select_oe} <= 3'h0;
        end else begin
            o_rx_data <= fifo_out_valid ? head.data : 8'h00;
            o_rx_ninth_bit <= fifo_out_valid & head.bit8;
            o_frame_error_flag <= fifo_out_valid & head.fe;
            o_parity_error_flag <= fifo_out_valid & head.pe & i_parity_enable_bit;
            o_overrun_flag <= (fifo_out_valid & head.dor) | ovr_pend;
            o_rx_complete_flag <= fifo_out_valid & rx_en;
            o_rx_irq <= fifo_out_valid & rx_en & i_rx_complete_irq_enable & i_global_irq_enable;
            o_serial_in_claimed <= rx_en;
            o_serial_out <= out_bit;
            o_serial_out_oe <= spi & (i_master | (spi_busy & ~ss_s));
            o_serial_clock_out <= sck_act;
            o_serial_clock_oe <= own_clk;
            o_slave_select_out <= ~spi_busy;
            o_slave_select_oe <= own_clk & ~i_slave_select_enable;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_start_check;
        state == ST_START && async_evt;
    endsequence
    sequence s_stop_taken;
        frame_done && fifo_in_ready && !ovr_pend;
    endsequence

    a_rxc_follows_buffer: assert property ((fifo_out_valid && rx_en) |=> o_rx_complete_flag)
        else $error("complete flag low with data buffered");
    a_irq_gating: assert property (o_rx_irq |-> o_rx_complete_flag
        && $past(i_rx_complete_irq_enable && i_global_irq_enable))
        else $error("interrupt without flag or enables");
    a_disable_flush: assert property (!rx_en |=> !o_rx_complete_flag && state == ST_IDLE ##1 !fifo_out_valid)
        else $error("disable did not flush receiver");
    a_parity_off_zero: assert property (!i_parity_enable_bit |=> !o_parity_error_flag || $changed(i_parity_enable_bit))
        else $error("parity error shown with parity off");
    a_overrun_set: assert property ((rx_en && push_req && !fifo_in_ready) |=> ovr_pend ##1 o_overrun_flag || !rx_en)
        else $error("overrun not flagged on full buffer");
    a_start_vote: assert property (s_start_check |=> (state == ($past(maj) ? ST_IDLE : ST_DATA)) || !$past(rx_en))
        else $error("start bit decision wrong");
    a_oversample_wrap: assert property ((async && state != ST_IDLE && tick && cnt == os_len && !async_fall)
        |=> cnt == 5'h01)
        else $error("sample counter did not wrap at bit length");
    a_stop_frame_err: assert property (s_stop_taken |-> fifo_in.fe == !bit_val ##1 fifo_out_valid)
        else $error("frame error does not match stop sample");
    a_spi_master_go: assert property ((spi_start_m && !i_data_write) |=> spi_busy && o_tx_buffer_empty_flag)
        else $error("spi transfer did not start on write");
endmodule
`default_nettype wire

// ### test/usr_peer_model.sv
// far-side model: uart transmitter and spi master driving the receiver pins
`timescale 1ns/1ps
`default_nettype none
module usr_peer_model (
    input wire logic i_clk,
    output logic o_line,
    output logic o_sck,
    output logic o_ssn
);
    initial begin
        o_line = 1'b1;
        o_sck = 1'b0;
        o_ssn = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic uart_frame(input logic [8:0] d, input int nb, input logic parity_error_flag, input logic pbit,
                              input logic stopv, input int bc);
        o_line = 1'b0;
        hold(bc);
        for (int i = 0; i < nb; i++) begin
            o_line = d[i];
            hold(bc);
        end
        if (parity_error_flag) begin
            o_line = pbit;
            hold(bc);
        end
        o_line = stopv;
        hold(bc);
        o_line = 1'b1;
        hold(bc);
    endtask
    // low pulse too short to reach the centre samples
    task automatic glitch(input int n);
        o_line = 1'b0;
        hold(n);
        o_line = 1'b1;
        hold(64);
    endtask
    // synchronous frame, data set mid-low, sampled on the falling link clock edge
    task automatic sync_frame(input logic [8:0] d, input int nb);
        logic [10:0] s;
        s = {1'b1, d, 1'b0};
        s[nb + 1] = 1'b1;
        for (int i = 0; i <= nb + 1; i++) begin
            o_line = s[i];
            hold(4);
            o_sck = 1'b1;
            hold(4);
            o_sck = 1'b0;
            hold(4);
        end
    endtask
    // half period of 4 clocks gives the 400 ns link clock, msb first
    task automatic spi_byte(input logic [7:0] d, input logic cpol, input logic cpha);
        o_sck = cpol;
        hold(4);
        o_ssn = 1'b0;
        if (!cpha) o_line = d[7];
        for (int i = 7; i >= 0; i--) begin
            hold(4);
            o_sck = ~cpol;
            if (cpha) o_line = d[i];
            hold(4);
            o_sck = cpol;
            if (!cpha && i > 0) o_line = d[i-1];
        end
        hold(4);
        o_ssn = 1'b1;
        o_line = ~o_line;
        hold(8);
    endtask
endmodule
`default_nettype wire

// ### test/usr_rx_top_tb.sv
// self-checking bench for the serial receiver and spi framing
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t %s", $time, m); end end
module usr_rx_top_tb import usr_pkg::*;;
    logic clk = 1'b0;
    logic i_resetn = 1'b0;
    logic rx_en = 1'b1;
    logic [1:0] mode = MODE_ASYNC;
    logic [2:0] cs = 3'h0;
    logic parity_error_flag = 1'b0;
    logic podd = 1'b0;
    logic dbl = 1'b0;
    logic master = 1'b0;
    logic cpol = 1'b0;
    logic cpha = 1'b0;
    logic ss_en = 1'b1;
    logic irq_en = 1'b0;
    logic gie = 1'b0;
    logic baud_tick = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic i_data_read = 1'b0;
    logic auto_read = 1'b1;
    logic line, sck, slave_select_pin;
    logic [7:0] o_rx_data;
    logic o_rx_ninth_bit, o_frame_error_flag, o_overrun_flag, o_parity_error_flag;
    logic o_rx_complete_flag, o_rx_irq, o_tx_buffer_empty_flag, o_serial_out, o_serial_out_oe;
    logic o_serial_clock_out, o_serial_clock_oe, o_slave_select_out, o_slave_select_oe, o_serial_in_claimed;
    int n_errors = 0;
    int check_count = 0;
    usr_entry_t expq[$];

    usr_rx_top usr_rx_top_inst (.i_clk(clk), .i_resetn(i_resetn), .i_rx_enable_bit(rx_en),
        .i_operating_mode_field(mode), .i_char_size_field(cs), .i_parity_enable_bit(parity_error_flag),
        .i_parity_odd(podd), .i_double_speed_bit(dbl), .i_master(master), .i_clock_polarity_bit(cpol),
        .i_clock_phase_bit(cpha), .i_lsb_first(1'b0), .i_slave_select_enable(ss_en),
        .i_rx_complete_irq_enable(irq_en), .i_global_irq_enable(gie), .i_baud_tick(baud_tick),
        .i_serial_in_pin(line), .i_serial_clock_pin(sck), .i_slave_select_pin(slave_select_pin), .i_data_write(wr),
        .i_write_data(wdata), .i_data_read(i_data_read), .o_rx_data(o_rx_data),
        .o_rx_ninth_bit(o_rx_ninth_bit), .o_frame_error_flag(o_frame_error_flag),
        .o_overrun_flag(o_overrun_flag), .o_parity_error_flag(o_parity_error_flag),
        .o_rx_complete_flag(o_rx_complete_flag), .o_rx_irq(o_rx_irq),
        .o_tx_buffer_empty_flag(o_tx_buffer_empty_flag), .o_serial_out(o_serial_out),
        .o_serial_out_oe(o_serial_out_oe), .o_serial_clock_out(o_serial_clock_out),
        .o_serial_clock_oe(o_serial_clock_oe), .o_slave_select_out(o_slave_select_out),
        .o_slave_select_oe(o_slave_select_oe), .o_serial_in_claimed(o_serial_in_claimed));
    usr_peer_model usr_peer_model_inst (.i_clk(clk), .o_line(line), .o_sck(sck), .o_ssn(slave_select_pin));

    initial begin
        forever #25 clk = ~clk;
    end
    // oversample tick every second clock: 32 clocks per bit normal, 16 double
    always @(negedge clk) baud_tick <= ~baud_tick;

    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin : monitor_p
        usr_entry_t e;
        forever begin
            @(negedge clk);
            if (auto_read && o_rx_complete_flag === 1'b1) begin
                if (expq.size() == 0) begin
                    `CHK(1'b0, 1'b1, "entry without note")
                end else begin
                    e = expq.pop_front();
                    `CHK(o_rx_data, e.data, "data")
                    `CHK(o_rx_ninth_bit, e.bit8, "ninth bit")
                    `CHK(o_frame_error_flag, e.fe, "frame error")
                    `CHK(o_parity_error_flag, e.pe, "parity error")
                    `CHK(o_overrun_flag, 1'b0, "overrun")
                    `CHK(o_rx_irq, irq_en & gie, "irq")
                end
                i_data_read = 1'b1;
                @(negedge clk);
                i_data_read = 1'b0;
                repeat (3) @(negedge clk);
            end
        end
    end

    initial begin : watchdog_p
        repeat (80000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    task automatic frame(input logic [2:0] c, input logic p, input logic po, input logic pflip,
                         input logic stopv, input logic db, input logic note);
        int nb;
        logic [8:0] d;
        usr_entry_t e;
        nb = (c == CS_NINE) ? 9 : int'(c) + 5;
        d = 9'($urandom) & 9'((1 << nb) - 1);
        @(negedge clk);
        cs = c;
        parity_error_flag = p;
        podd = po;
        dbl = db;
        irq_en = 1'($urandom);
        gie = 1'($urandom);
        e = '{dor: 1'b0, fe: ~stopv, pe: p & pflip, bit8: (nb == 9) ? d[8] : 1'b0, data: d[7:0]};
        if (note) expq.push_back(e);
        usr_peer_model_inst.uart_frame(d, nb, p, ^d ^ po ^ pflip, stopv, db ? 16 : 32);
    endtask

    initial begin : main_p
        logic [2:0] sizes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, CS_NINE};
        logic [7:0] b;
        int edges;
        logic [7:0] mosi;
        void'($urandom(81431));
        repeat (2) @(posedge clk);
        @(negedge clk);
        i_resetn = 1'b1;
        `CHK(o_tx_buffer_empty_flag, 1'b1, "empty after reset")
        `CHK(o_rx_complete_flag, 1'b0, "complete after reset")
        repeat (4) @(negedge clk);
        foreach (sizes[k]) begin
            frame(sizes[k], 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
            frame(sizes[k], 1'b1, sizes[k][0], 1'b0, 1'b1, 1'b1, 1'b1);
        end
        frame(3'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        frame(3'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        frame(CS_NINE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        frame(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        dbl = 1'b0;
        usr_peer_model_inst.glitch(6);
        frame(3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        repeat (20) @(negedge clk);
        `CHK(expq.size(), 0, "notes left over")
        // overrun: fill both entries, a third frame is lost
        auto_read = 1'b0;
        repeat (3) frame(3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        `CHK(o_rx_complete_flag, 1'b1, "full complete")
        `CHK(o_overrun_flag, 1'b1, "overrun set")
        rx_en = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(o_rx_complete_flag, 1'b0, "flush")
        `CHK(o_rx_irq, 1'b0, "irq after flush")
        `CHK(o_serial_in_claimed, 1'b0, "pin released")
        frame(3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        `CHK(o_rx_complete_flag, 1'b0, "disabled receiver")
        rx_en = 1'b1;
        auto_read = 1'b1;
        // synchronous frame on the pin clock, idle clock low
        @(negedge clk);
        mode = MODE_SYNC;
        cs = 3'h3;
        parity_error_flag = 1'b0;
        b = 8'($urandom);
        expq.push_back('{dor: 1'b0, fe: 1'b0, pe: 1'b0, bit8: 1'b0, data: b});
        usr_peer_model_inst.sync_frame({1'b0, b}, 8);
        // spi slave in all four clock formats
        for (int m = 0; m < 4; m++) begin
            @(negedge clk);
            mode = MODE_SPI;
            cpol = m[1];
            cpha = m[0];
            b = 8'($urandom);
            expq.push_back('{dor: 1'b0, fe: 1'b0, pe: 1'b0, bit8: 1'b0, data: b});
            usr_peer_model_inst.spi_byte(b, m[1], m[0]);
        end
        repeat (20) @(negedge clk);
        `CHK(expq.size(), 0, "spi notes left over")
        // spi master: a data write alone starts the clock
        auto_read = 1'b0;
        master = 1'b1;
        ss_en = 1'b0;
        cpol = 1'b0;
        cpha = 1'b0;
        repeat (4) @(negedge clk);
        wdata = 8'($urandom);
        wr = 1'b1;
        @(negedge clk);
        `CHK(o_tx_buffer_empty_flag, 1'b0, "empty cleared by write")
        wr = 1'b0;
        edges = 0;
        mosi = 8'h00;
        // select rises with the last clock edge, so judge each edge by the select before it
        for (int t = 0; t < 400 && o_rx_complete_flag !== 1'b1; t++) begin
            b[0] = o_serial_clock_out;
            b[1] = o_slave_select_out;
            @(negedge clk);
            if (o_serial_clock_out !== b[0] && b[1] === 1'b0) edges++;
            if (o_serial_clock_out === 1'b1 && b[0] === 1'b0 && b[1] === 1'b0) mosi = {mosi[6:0], o_serial_out};
        end
        `CHK(mosi, wdata, "master data out")
        `CHK(o_serial_out_oe, 1'b1, "data out driven")
        `CHK(o_rx_data, {8{line}}, "master data in")
        `CHK(edges, int'(SPI_EDGES), "master clock edges")
        `CHK(o_serial_clock_oe, 1'b1, "clock driven")
        `CHK(o_slave_select_oe, 1'b1, "select driven")
        `CHK(o_tx_buffer_empty_flag, 1'b1, "empty after load")
        `CHK(o_rx_complete_flag, 1'b1, "master byte received")
        rx_en = 1'b0;
        repeat (4) @(negedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
